// ---- common/pwi_pkg.sv ----
// Package for the parallel word interface: register offsets, field positions and timing.
// Assumes a 100 MHz clock and a simple synchronous register port from the processor side.
// Summary of operation
// - Bit 15 shows second request input.
// - Second request with bit 05 raises interrupt.
// - Bits 14-8 and 4-2 read zero.
// - Bit 07 first request; interrupts with bit 06.
// - Requests read-only; initialize clears in loopback.
// - Loopback: second request follows command bit one.
// - Loopback: first request follows command bit zero.
// - First enable read/write, cleared by initialize.
// - Second enable read/write, cleared by initialize.
// - Command bit one read/write, drives connector one.
// - Command bit zero read/write, drives connector two.
// - Output buffer sixteen bits, word or byte writes.
// - Output buffer reads back stored contents.
// - Input buffer read returns whole input word.
// - Input read gives 300 ns accepted pulse.
// - Initialize clears buffer, enables, commands, interrupt state.
// - Offsets 0, 2, 4 select the three registers.
// - Two vectors: base for first, base+4 second.
package pwi_pkg;
  localparam logic [2:0] PWI_OFF_CSR = 3'h0;
  localparam logic [2:0] PWI_OFF_OUT = 3'h2;
  localparam logic [2:0] PWI_OFF_IN = 3'h4;
  localparam int PWI_BIT_REQ_B = 15;
  localparam int PWI_BIT_REQ_A = 7;
  localparam int PWI_BIT_ENB_A = 6;
  localparam int PWI_BIT_ENB_B = 5;
  localparam int PWI_BIT_CMD1 = 1;
  localparam int PWI_BIT_CMD0 = 0;
  localparam logic [15:0] PWI_OUT_RESET = 16'h0000;
  localparam logic [7:0] PWI_VEC_B_OFFSET = 8'h04;
  localparam int PWI_CLK_MHZ = 100;
  localparam int PWI_PULSE_NS = 300;
  localparam int PWI_PULSE_CYC = (PWI_PULSE_NS * PWI_CLK_MHZ + 999) / 1000;
  localparam int PWI_FIFO_WIDTH = 16;
  localparam int PWI_FIFO_DEPTH = 4;

  typedef struct packed {
    logic sel;
    logic wr;
    logic byte_mode;
    logic [2:0] addr;
    logic [15:0] wdata;
  } pwi_req_t;

  typedef enum logic [1:0] {
    PWI_IDLE = 2'b00,
    PWI_PULSE = 2'b01
  } pwi_pulse_state_t;
endpackage

// ---- hw/pwi_fifo.sv ----
// Small synchronous FIFO for output words bound for the user device.
// Assumes one clock; the reader stalls with out_ready low.
`timescale 1ns/1ns
module pwi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rp_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= AW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= AW'(rp_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule

// ---- hw/pwi_pulse.sv ----
// Fixed-width pulse generator for the handshake strobes to the user device.
// Assumes a trigger that is a single-cycle request; triggers during a pulse are ignored.
`timescale 1ns/1ns
module pwi_pulse
  import pwi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic trigger,
  output logic pulse,
  output logic done
);
  pwi_pulse_state_t state_q;
  logic [7:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PWI_IDLE;
      cnt_q <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        PWI_IDLE: begin
          if (trigger) begin
            state_q <= PWI_PULSE;
            cnt_q <= 8'(PWI_PULSE_CYC - 1);
          end
        end
        PWI_PULSE: begin
          if (cnt_q == 8'h00) begin
            state_q <= PWI_IDLE;
            done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: state_q <= PWI_IDLE;
      endcase
    end
  end

  assign pulse = (state_q == PWI_PULSE);
endmodule

// ---- hw/pwi_top.sv ----
// Register side of the 16-bit parallel word interface.
// Assumes synchronous request inputs and a single-cycle register access strobe.
`timescale 1ns/1ns
module pwi_top
  import pwi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_initialize,
  input wire pwi_pkg::pwi_req_t req,
  input wire logic [1:0] byte_en,
  output logic [15:0] rdata,
  input wire logic [7:0] vector_base,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [7:0] irq_vector,
  input wire logic loopback,
  input wire logic request_a,
  input wire logic request_b,
  input wire logic [15:0] in_data,
  output logic data_accepted_pulse,
  output logic [15:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic new_data_ready,
  output logic command_bit_one,
  output logic command_bit_zero
);
  logic rst_all;
  logic first_irq_enable_q;
  logic second_irq_enable_q;
  logic cmd1_q;
  logic cmd0_q;
  logic [15:0] out_buf_q;
  logic req_a_eff;
  logic req_b_eff;
  logic irq_a_pend_q;
  logic irq_b_pend_q;
  logic wr_csr;
  logic wr_out;
  logic rd_in;
  logic [15:0] csr_view;
  logic fifo_in_ready;
  logic fifo_push_q;
  logic nd_trig;

  // Initialize behaves as a synchronous clear on top of the asynchronous reset.
  assign rst_all = bus_initialize;
  assign wr_csr = req.sel && req.wr && (req.addr == PWI_OFF_CSR);
  assign wr_out = req.sel && req.wr && (req.addr == PWI_OFF_OUT);
  assign rd_in = req.sel && !req.wr && (req.addr == PWI_OFF_IN);

  // In loopback the requests come from the command bits and clear with them on initialize.
  assign req_b_eff = loopback ? cmd1_q : request_b;
  assign req_a_eff = loopback ? cmd0_q : request_a;

  always_comb begin
    csr_view = 16'h0000;
    csr_view[PWI_BIT_REQ_B] = req_b_eff;
    csr_view[PWI_BIT_REQ_A] = req_a_eff;
    csr_view[PWI_BIT_ENB_A] = first_irq_enable_q;
    csr_view[PWI_BIT_ENB_B] = second_irq_enable_q;
    csr_view[PWI_BIT_CMD1] = cmd1_q;
    csr_view[PWI_BIT_CMD0] = cmd0_q;
  end

  // Request bits are never written; only enables and commands take the write data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_irq_enable_q <= 1'b0;
      second_irq_enable_q <= 1'b0;
      cmd1_q <= 1'b0;
      cmd0_q <= 1'b0;
    end else if (rst_all) begin
      first_irq_enable_q <= 1'b0;
      second_irq_enable_q <= 1'b0;
      cmd1_q <= 1'b0;
      cmd0_q <= 1'b0;
    end else if (wr_csr && byte_en[0]) begin
      first_irq_enable_q <= req.wdata[PWI_BIT_ENB_A];
      second_irq_enable_q <= req.wdata[PWI_BIT_ENB_B];
      cmd1_q <= req.wdata[PWI_BIT_CMD1];
      cmd0_q <= req.wdata[PWI_BIT_CMD0];
    end
  end

  assign command_bit_one = cmd1_q;
  assign command_bit_zero = cmd0_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_buf_q <= PWI_OUT_RESET;
    end else if (rst_all) begin
      out_buf_q <= PWI_OUT_RESET;
    end else if (wr_out) begin
      if (byte_en[1]) begin
        out_buf_q[15:8] <= req.wdata[15:8];
      end
      if (byte_en[0]) begin
        out_buf_q[7:0] <= req.wdata[7:0];
      end
    end
  end

  // The new word is queued one cycle after the write so that byte merges are complete.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_push_q <= 1'b0;
    end else begin
      fifo_push_q <= wr_out && !rst_all;
    end
  end

  // A full queue drops the word; software sees the buffer value regardless.
  pwi_fifo #(
    .WIDTH(PWI_FIFO_WIDTH),
    .DEPTH(PWI_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_push_q),
    .in_ready(fifo_in_ready),
    .in_data(out_buf_q),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  assign nd_trig = fifo_push_q && fifo_in_ready;

  pwi_pulse u_nd_pulse (
    .clk(clk),
    .rst(rst),
    .trigger(nd_trig),
    .pulse(new_data_ready),
    .done()
  );

  // The input word is not latched, so the user must hold it through this pulse.
  pwi_pulse u_da_pulse (
    .clk(clk),
    .rst(rst),
    .trigger(rd_in),
    .pulse(data_accepted_pulse),
    .done()
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (req.sel && !req.wr) begin
      case (req.addr)
        PWI_OFF_CSR: rdata <= csr_view;
        PWI_OFF_OUT: rdata <= out_buf_q;
        PWI_OFF_IN: rdata <= in_data;
        default: rdata <= 16'h0000;
      endcase
    end
  end

  // Pending flags are set by an enabled request and cleared by acknowledge, B only once A is clear; set wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_a_pend_q <= 1'b0;
      irq_b_pend_q <= 1'b0;
    end else if (rst_all) begin
      irq_a_pend_q <= 1'b0;
      irq_b_pend_q <= 1'b0;
    end else begin
      if (req_a_eff && first_irq_enable_q) begin
        irq_a_pend_q <= 1'b1;
      end else if (irq_ack && irq_a_pend_q) begin
        irq_a_pend_q <= 1'b0;
      end
      if (req_b_eff && second_irq_enable_q) begin
        irq_b_pend_q <= 1'b1;
      end else if (irq_ack && !irq_a_pend_q && irq_b_pend_q) begin
        irq_b_pend_q <= 1'b0;
      end
    end
  end

  assign irq_req = irq_a_pend_q || irq_b_pend_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_vector <= 8'h00;
    end else if (irq_a_pend_q) begin
      irq_vector <= vector_base;
    end else begin
      irq_vector <= 8'(vector_base + PWI_VEC_B_OFFSET);
    end
  end
endmodule

// ---- verification/pwi_bench.sv ----
// Self-checking bench for pwi_top.
// Uses the user device model on the far side.
`timescale 1ns/1ns
module pwi_bench;
  import pwi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic init = 1'b0;
  logic ack = 1'b0;
  logic loop = 1'b0;
  logic set_a = 1'b0;
  logic set_b = 1'b0;
  logic stall = 1'b0;
  logic [1:0] be = 2'h3;
  logic [7:0] vbase = 8'h30;
  pwi_req_t req = '0;
  logic [15:0] rdata, ind, od;
  logic [7:0] ivec;
  logic irq, ra, rb, dap, ov, ordy, ndr, c1, c0;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  pwi_top dut (.clk(clk), .rst(rst), .bus_initialize(init), .req(req), .byte_en(be), .rdata(rdata),
    .vector_base(vbase), .irq_ack(ack), .irq_req(irq), .irq_vector(ivec), .loopback(loop),
    .request_a(ra), .request_b(rb), .in_data(ind), .data_accepted_pulse(dap), .out_data(od),
    .out_valid(ov), .out_ready(ordy), .new_data_ready(ndr), .command_bit_one(c1), .command_bit_zero(c0));
  pwi_user_device usr (.clk(clk), .rst(rst), .set_a(set_a), .set_b(set_b), .stall(stall),
    .data_accepted_pulse(dap), .new_data_ready(ndr), .out_valid(ov), .out_data(od),
    .request_a(ra), .request_b(rb), .in_data(ind), .out_ready(ordy));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge clk);
    req <= '{1'b1, w, 1'b0, a, d};
    be <= b;
    @(posedge clk);
    req.sel <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic ini();
    @(posedge clk);
    init <= 1'b1;
    @(posedge clk);
    init <= 1'b0;
  endtask
  task automatic t_csr();
    acc(1'b1, PWI_OFF_CSR, 16'hffff, 2'h3);
    acc(1'b0, PWI_OFF_CSR, 16'h0000, 2'h3);
    chk(rdata, 16'h0063);
    chk({14'h0, c1, c0}, 16'h0003);
    ini();
    acc(1'b0, PWI_OFF_CSR, 16'h0000, 2'h3);
    chk(rdata, 16'h0000);
    $display("status word test done");
  endtask
  task automatic t_loop();
    @(posedge clk);
    loop <= 1'b1;
    acc(1'b1, PWI_OFF_CSR, 16'h0001, 2'h3);
    acc(1'b0, PWI_OFF_CSR, 16'h0000, 2'h3);
    chk(rdata, 16'h0081);
    acc(1'b1, PWI_OFF_CSR, 16'h0002, 2'h3);
    acc(1'b0, PWI_OFF_CSR, 16'h0000, 2'h3);
    chk(rdata, 16'h8002);
    ini();
    acc(1'b0, PWI_OFF_CSR, 16'h0000, 2'h3);
    chk(rdata, 16'h0000);
    loop <= 1'b0;
    $display("loopback test done");
  endtask
  task automatic t_in();
    acc(1'b0, PWI_OFF_IN, 16'h0000, 2'h3);
    chk(rdata, 16'h5a3c);
    chk({15'h0, dap}, 16'h0001);
    // A read during the 30-cycle pulse starts no new pulse, so the next read waits it out.
    repeat (40) @(posedge clk);
    #1;
    chk({15'h0, dap}, 16'h0000);
    acc(1'b0, PWI_OFF_IN, 16'h0000, 2'h3);
    chk(rdata, 16'ha5c3);
    repeat (40) @(posedge clk);
    $display("input test done");
  endtask
  task automatic t_out();
    @(posedge clk);
    stall <= 1'b1;
    acc(1'b1, PWI_OFF_OUT, 16'h1234, 2'h3);
    chk({15'h0, ndr}, 16'h0001);
    acc(1'b1, PWI_OFF_OUT, 16'hab00, 2'h2);
    acc(1'b0, PWI_OFF_OUT, 16'h0000, 2'h3);
    chk(rdata, 16'hab34);
    for (int i = 1; i <= 3; i++) begin
      acc(1'b1, PWI_OFF_OUT, 16'(i), 2'h3);
    end
    chk({15'h0, ov}, 16'h0001);
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk(16'(usr.got_q.size()), 16'h0004);
    chk(usr.got_q[1], 16'hab34);
    chk(usr.got_q[3], 16'h0002);
    $display("output test done");
  endtask
  task automatic t_irq(input logic b, input logic [15:0] enb, input logic [7:0] vec, input logic exp);
    acc(1'b1, PWI_OFF_CSR, enb, 2'h3);
    set_a <= !b;
    set_b <= b;
    @(posedge clk);
    set_a <= 1'b0;
    set_b <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0, irq}, {15'h0, exp});
    if (exp) begin
      chk({8'h00, ivec}, {8'h00, vec});
    end
    acc(1'b1, PWI_OFF_CSR, 16'h0000, 2'h3);
    acc(1'b0, PWI_OFF_IN, 16'h0000, 2'h3);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0000);
    $display("interrupt test done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_csr();
    t_loop();
    t_in();
    t_out();
    t_irq(1'b1, 16'h0020, 8'h34, 1'b1);
    t_irq(1'b0, 16'h0040, 8'h30, 1'b1);
    t_irq(1'b0, 16'h0020, 8'h30, 1'b0);
    conclude();
  end
endmodule

// ---- verification/pwi_top_asserts.sv ----
// Checker for pwi_top.
// Sees only the top module's ports; bound below.
`timescale 1ns/1ns
module pwi_top_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_initialize,
  input wire pwi_pkg::pwi_req_t req,
  input wire logic [15:0] rdata,
  input wire logic irq_req,
  input wire logic loopback,
  input wire logic request_a,
  input wire logic request_b,
  input wire logic [15:0] in_data,
  input wire logic data_accepted_pulse,
  input wire logic new_data_ready,
  input wire logic command_bit_one,
  input wire logic command_bit_zero
);
  import pwi_pkg::*;
  logic rd_c;
  logic rd_i;
  logic [7:0] da_len_q;
  logic [7:0] nd_len_q;
  // The pulses last 30 cycles, too long for a repetition, so their high time is counted here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      da_len_q <= 8'h00;
      nd_len_q <= 8'h00;
    end else begin
      da_len_q <= data_accepted_pulse ? 8'(da_len_q + 8'h01) : 8'h00;
      nd_len_q <= new_data_ready ? 8'(nd_len_q + 8'h01) : 8'h00;
    end
  end
  assign rd_c = req.sel && !req.wr && req.addr == PWI_OFF_CSR;
  assign rd_i = req.sel && !req.wr && req.addr == PWI_OFF_IN;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  zero_bits_a: assert property (rd_c |=> rdata[14:8] == 7'h00 && rdata[4:2] == 3'h0)
    else $error("unused bits set");
  flag_b_a: assert property (rd_c && !loopback |=> rdata[15] == $past(request_b))
    else $error("bit 15 wrong");
  flag_a_a: assert property (rd_c && !loopback |=> rdata[7] == $past(request_a))
    else $error("bit 7 wrong");
  loop_b_a: assert property (rd_c && loopback |=> rdata[15] == $past(command_bit_one))
    else $error("loop bit 15 wrong");
  loop_a_a: assert property (rd_c && loopback |=> rdata[7] == $past(command_bit_zero))
    else $error("loop bit 7 wrong");
  in_word_a: assert property (rd_i |=> rdata == $past(in_data))
    else $error("input word wrong");
  accept_width_a: assert property ($fell(data_accepted_pulse) |-> da_len_q == 8'(PWI_PULSE_CYC))
    else $error("accept pulse width");
  accept_cause_a: assert property ($rose(data_accepted_pulse) |-> $past(rd_i) || $past(rd_i, 2))
    else $error("accept pulse unasked");
  ready_width_a: assert property ($fell(new_data_ready) |-> nd_len_q == 8'(PWI_PULSE_CYC))
    else $error("ready pulse width");
  init_clear_a: assert property (bus_initialize |=> !command_bit_one && !command_bit_zero)
    else $error("commands not cleared");
  irq_cause_a: assert property ($rose(irq_req) |-> $past(request_a || request_b || loopback))
    else $error("interrupt without request");
  cover property ($rose(data_accepted_pulse));
  cover property ($rose(new_data_ready));
  cover property ($rose(irq_req));
endmodule
bind pwi_top pwi_top_asserts chk (.clk(clk), .rst(rst), .bus_initialize(bus_initialize), .req(req),
  .rdata(rdata), .irq_req(irq_req), .loopback(loopback), .request_a(request_a), .request_b(request_b),
  .in_data(in_data), .data_accepted_pulse(data_accepted_pulse), .new_data_ready(new_data_ready),
  .command_bit_one(command_bit_one), .command_bit_zero(command_bit_zero));

// ---- verification/pwi_user_device.sv ----
// Model of the user's device.
// The bench steers its request flags and stall.
`timescale 1ns/1ns
module pwi_user_device (
  input wire logic clk,
  input wire logic rst,
  input wire logic set_a,
  input wire logic set_b,
  input wire logic stall,
  input wire logic data_accepted_pulse,
  input wire logic new_data_ready,
  input wire logic out_valid,
  input wire logic [15:0] out_data,
  output logic request_a,
  output logic request_b,
  output logic [15:0] in_data,
  output logic out_ready
);
  logic [15:0] got_q[$];
  logic dap_q;
  assign out_ready = !stall;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      request_a <= 1'b0;
      request_b <= 1'b0;
      in_data <= 16'h5a3c;
      dap_q <= 1'b0;
    end else begin
      request_a <= set_a || (request_a && !data_accepted_pulse && !new_data_ready);
      request_b <= set_b || (request_b && !data_accepted_pulse && !new_data_ready);
      dap_q <= data_accepted_pulse;
      // Inverting after the pulse makes a stale read visible.
      if (dap_q && !data_accepted_pulse) begin
        in_data <= ~in_data;
      end
      if (out_valid && out_ready) begin
        got_q.push_back(out_data);
      end
    end
  end
endmodule
